// [src/pmr_cfg.svh]
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

// apb address decode (byte addresses, one word per register)
`define PMR_ADDR_W 8
`define PMR_CAPS_ADDR 8'hA0
`define PMR_CSR_ADDR 8'hA4
`define PMR_LINK_ADDR 8'hA8

// control/status field positions
`define PMR_CSR_STAT_BIT 15
`define PMR_CSR_EN_BIT 8
`define PMR_CSR_PS_MSB 1
`define PMR_CSR_PS_LSB 0
`define PMR_CSR_RESET 16'h0000

// capabilities field positions and fixed values
`define PMR_CAPS_D3COLD_BIT 15
`define PMR_CAPS_WAKE_FIXED 4'hF
`define PMR_CAPS_DSUP_FIXED 2'h3
`define PMR_CAPS_RSVD_VAL 3'h0
`define PMR_CAPS_DSI_VAL 1'h0
`define PMR_CAPS_AUX_VAL 1'h1
`define PMR_CAPS_CLK_VAL 1'h0
`define PMR_CAPS_VERSION 3'h2
`define PMR_D3COLD_RESET 1'h1

// link status register bits
`define PMR_LINK_DRIVE_BIT 0
`define PMR_LINK_LINE_BIT 1
`define PMR_LINK_IRST_BIT 2
`define PMR_LINK_BRST_BIT 3

// internal reset pulse length in ref_clk cycles
`define PMR_IRST_CYCLES 3'h4

`endif

// [src/pmr_pkg.sv]
package pmr_pkg;

  typedef enum logic [1:0] {
    PMR_D0 = 2'h0,
    PMR_D1 = 2'h1,
    PMR_D2 = 2'h2,
    PMR_D3HOT = 2'h3
  } pmr_pstate_t;

  typedef enum logic [1:0] {
    PMR_IRST_IDLE = 2'h1,
    PMR_IRST_BUSY = 2'h2
  } pmr_irst_state_t;

endpackage

// [src/pmr_regs.sv]
// How it works
// - capability bits 8 to 6 always read as zero.
// - device-specific-initialization capability bit 5 always reads zero.
// - aux supply bit 4 reads zero whenever the D3cold wake bit is zero.
// - bit 3 says if wake needs the bus clock; zero if no wake.
// - capability bits 2 to 0 read the constant version code 010.
// - leaving D3hot for D0 outside bus reset pulses a function reset for other registers.
// - that internal reset leaves the control/status register untouched.
// - wake status sets on every wake event, enabled or not.
// - writing one clears wake status and releases the wake pin; zero ignored.
// - bus reset clears wake status only while wake is disabled.
// - data-scale field bits 14 to 13 always read zero.
// - data-select field bits 12 to 9 always read zero.
// - the wake pin is driven only while the wake enable bit is set.
// - wake enable survives bus reset; only global reset clears it.
// - control/status bits 7 to 2 always read zero.
// - power state field reads the current state and writes move it.
// - D3cold wake capability bit is writable and resets to one.
`timescale 1ns/1ps
`include "pmr_cfg.svh"
module pmr_regs (
  // clock and global reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PMR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from the bus side
  input wire logic bus_reset_n,
  input wire logic wake_event,
  // open-drain wake pin, active low
  input wire logic wake_n_i,
  output logic wake_n_o,
  output logic wake_n_oe,
  // state to the rest of the function
  output pmr_pkg::pmr_pstate_t power_state,
  output logic internal_reset
);
  import pmr_pkg::*;

  // pin synchronisers
  logic [2:0] pins_sync;
  logic bus_rst;
  logic wake_evt;
  logic wake_line_low;

  pmr_sync #(
    .W(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in({~bus_reset_n, wake_event, ~wake_n_i}),
    .sync_out(pins_sync)
  );

  assign bus_rst = pins_sync[2];
  assign wake_evt = pins_sync[1];
  assign wake_line_low = pins_sync[0];

  // apb decode
  logic setup;
  logic access;
  logic wr_en;
  logic hit_caps;
  logic hit_csr;
  logic hit_link;
  logic hit_any;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_caps = (paddr == `PMR_CAPS_ADDR);
  assign hit_csr = (paddr == `PMR_CSR_ADDR);
  assign hit_link = (paddr == `PMR_LINK_ADDR);
  assign hit_any = hit_caps || hit_csr || hit_link;
  assign wr_en = access && pwrite && hit_any;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  // register state
  pmr_pstate_t pstate_r, pstate_nxt;
  logic wake_en_r, wake_en_nxt;
  logic wake_stat_r, wake_stat_nxt;
  logic d3cold_r, d3cold_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  logic wr_lane0;
  logic wr_lane1;
  logic wake_clear;
  logic irst;

  assign wr_lane0 = wr_en && pstrb[0];
  assign wr_lane1 = wr_en && pstrb[1];
  assign wake_clear = wr_lane1 && hit_csr && pwdata[`PMR_CSR_STAT_BIT];

  // composed read views
  logic [15:0] caps_view;
  logic [15:0] csr_view;
  logic [15:0] link_view;
  logic aux_bit;
  logic clk_bit;
  logic any_wake_state;

  assign any_wake_state = d3cold_r || (|`PMR_CAPS_WAKE_FIXED);
  assign aux_bit = d3cold_r ? `PMR_CAPS_AUX_VAL : 1'b0;
  assign clk_bit = any_wake_state ? `PMR_CAPS_CLK_VAL : 1'b0;

  always_comb begin
    caps_view = 16'h0000;
    caps_view[`PMR_CAPS_D3COLD_BIT] = d3cold_r;
    caps_view[14:11] = `PMR_CAPS_WAKE_FIXED;
    caps_view[10:9] = `PMR_CAPS_DSUP_FIXED;
    caps_view[8:6] = `PMR_CAPS_RSVD_VAL;
    caps_view[5] = `PMR_CAPS_DSI_VAL;
    caps_view[4] = aux_bit;
    caps_view[3] = clk_bit;
    caps_view[2:0] = `PMR_CAPS_VERSION;
  end

  always_comb begin
    // scale, select and reserved fields stay at zero
    csr_view = 16'h0000;
    csr_view[`PMR_CSR_STAT_BIT] = wake_stat_r;
    csr_view[`PMR_CSR_EN_BIT] = wake_en_r;
    csr_view[`PMR_CSR_PS_MSB:`PMR_CSR_PS_LSB] = pstate_r;
  end

  always_comb begin
    link_view = 16'h0000;
    link_view[`PMR_LINK_DRIVE_BIT] = wake_n_oe;
    link_view[`PMR_LINK_LINE_BIT] = wake_line_low;
    link_view[`PMR_LINK_IRST_BIT] = irst;
    link_view[`PMR_LINK_BRST_BIT] = bus_rst;
  end

  // next-state logic for the power-management fields
  always_comb begin
    pstate_nxt = pstate_r;
    wake_en_nxt = wake_en_r;
    wake_stat_nxt = wake_stat_r;
    d3cold_nxt = d3cold_r;

    // only the writable bits of the capabilities word take writes
    if (wr_lane1 && hit_caps) begin
      d3cold_nxt = pwdata[`PMR_CAPS_D3COLD_BIT];
    end

    if (wr_lane0 && hit_csr) begin
      pstate_nxt = pmr_pstate_t'(pwdata[`PMR_CSR_PS_MSB:`PMR_CSR_PS_LSB]);
    end

    if (wr_lane1 && hit_csr) begin
      wake_en_nxt = pwdata[`PMR_CSR_EN_BIT];
    end

    // write-one-to-clear; a zero written leaves the bit alone
    if (wake_clear) begin
      wake_stat_nxt = 1'b0;
    end

    // bus reset: state back to D0, wake status only when wake is disabled
    if (bus_rst) begin
      pstate_nxt = PMR_D0;
      if (!wake_en_r) begin
        wake_stat_nxt = 1'b0;
      end
      // wake enable is kept here on purpose
      wake_en_nxt = wake_en_r;
    end

    // an event in the clearing cycle wins over the clear
    if (wake_evt) begin
      wake_stat_nxt = 1'b1;
    end
  end

  // read data is captured in the setup phase, valid through access
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      if (hit_caps) begin
        prdata_nxt[15:0] = caps_view;
      end
      if (hit_csr) begin
        prdata_nxt[15:0] = csr_view;
      end
      if (hit_link) begin
        prdata_nxt[15:0] = link_view;
      end
    end
  end

  // rstn is the global reset; the internal reset is not wired in here
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pstate_r <= PMR_D0;
      wake_en_r <= 1'b0;
      wake_stat_r <= 1'b0;
      d3cold_r <= `PMR_D3COLD_RESET;
      prdata_r <= 32'h0000_0000;
    end else begin
      // internal reset pulse has no effect on these fields
      pstate_r <= pstate_nxt;
      wake_en_r <= wake_en_nxt;
      wake_stat_r <= wake_stat_nxt;
      d3cold_r <= d3cold_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // internal function reset on leaving D3hot for D0
  pmr_reset_pulse u_irst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pstate(pstate_r),
    .bus_rst(bus_rst),
    .irst(irst)
  );

  assign internal_reset = irst;
  assign power_state = pstate_r;

  // open-drain wake pin: pull low while status is set and enabled
  assign wake_n_o = 1'b0;
  assign wake_n_oe = wake_stat_r && wake_en_r;
endmodule // pmr_regs

// [src/pmr_reset_pulse.sv]
`timescale 1ns/1ps
`include "pmr_cfg.svh"
module pmr_reset_pulse (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // power state watch
  input pmr_pkg::pmr_pstate_t pstate,
  input wire logic bus_rst,
  // internal function reset
  output logic irst
);
  import pmr_pkg::*;

  pmr_pstate_t prev_r, prev_nxt;
  pmr_irst_state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;

  always_comb begin
    prev_nxt = pstate;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      PMR_IRST_IDLE: begin
        // bus reset already clears the function; no extra pulse then
        if (prev_r == PMR_D3HOT && pstate == PMR_D0 && !bus_rst) begin
          state_nxt = PMR_IRST_BUSY;
          cnt_nxt = `PMR_IRST_CYCLES - 3'h1;
        end
      end
      PMR_IRST_BUSY: begin
        if (cnt_r == 3'h0) begin
          state_nxt = PMR_IRST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: begin
        state_nxt = PMR_IRST_IDLE;
        cnt_nxt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prev_r <= PMR_D0;
      state_r <= PMR_IRST_IDLE;
      cnt_r <= 3'h0;
    end else begin
      prev_r <= prev_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign irst = (state_r == PMR_IRST_BUSY);
endmodule // pmr_reset_pulse

// [src/pmr_sync.sv]
`timescale 1ns/1ps
module pmr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // pins in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;
endmodule // pmr_sync

// [verif/pmr_props.sv]
`timescale 1ns/1ps
`include "pmr_cfg.svh"
module pmr_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PMR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // pins and state
  input wire logic bus_reset_n,
  input wire logic wake_event,
  input wire logic wake_n_oe,
  input pmr_pkg::pmr_pstate_t power_state,
  input wire logic internal_reset
);
  import pmr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic acc, unmap, rd_csr, wr_csr;
  logic [1:0] wr_ps;
  assign acc = psel && penable;
  assign unmap = paddr != `PMR_CAPS_ADDR && paddr != `PMR_CSR_ADDR
    && paddr != `PMR_LINK_ADDR;
  assign rd_csr = acc && !pwrite && paddr == `PMR_CSR_ADDR;
  assign wr_csr = acc && pwrite && paddr == `PMR_CSR_ADDR;
  assign wr_ps = pwdata[1:0];
  AST_IRST_CAUSE:
    assert property ($rose(internal_reset) |->
      $past(power_state, 2) == PMR_D3HOT) else $error("pulse without exit");
  AST_IRST_LEN:
    assert property ($rose(internal_reset) |->
      internal_reset [*4] ##1 !internal_reset) else $error("pulse length");
  AST_UNMAPPED:
    assert property (acc |-> pslverr == unmap &&
      (pwrite || !unmap || prdata == 32'h0)) else $error("bad error flag");
  AST_PS_WRITE:
    assert property (wr_csr && pstrb[0] && bus_reset_n &&
      $past(bus_reset_n) && $past(bus_reset_n, 2) |=>
      power_state == $past(wr_ps)) else $error("state not written");
  AST_PS_READ:
    assert property (rd_csr |-> prdata[1:0] == power_state)
      else $error("state read back wrong");
  AST_CSR_ZERO:
    assert property (rd_csr |-> prdata[31:16] == 16'h0 &&
      prdata[14:9] == 6'h0 && prdata[7:2] == 6'h0) else $error("csr zeros");
  AST_CAPS:
    assert property (acc && !pwrite && paddr == `PMR_CAPS_ADDR |->
      prdata[8:0] == {4'h0, prdata[15], 4'h2}) else $error("caps low bits");
  AST_W1C:
    assert property (wr_csr && pstrb[1] && pwdata[15] && !wake_event &&
      !$past(wake_event) && !$past(wake_event, 2) &&
      !$past(wake_event, 3) |=> ##1 !wake_n_oe) else $error("pin not freed");
  AST_KEEP_OE:
    assert property (wake_n_oe && !bus_reset_n && !(psel && pwrite &&
      paddr == `PMR_CSR_ADDR) |=> wake_n_oe) else $error("bus reset drop");
  cover property ($rose(internal_reset));
  cover property (wake_n_oe && !bus_reset_n);
  cover property (acc && pslverr);
endmodule // pmr_props

bind pmr_regs pmr_props u_props (.ref_clk, .rstn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .bus_reset_n,
  .wake_event, .wake_n_oe, .power_state, .internal_reset);

// [verif/pmr_regs_tb.sv]
`timescale 1ns/1ps
module pmr_regs_tb;
  import pmr_pkg::*;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic bus_reset_n, wake_event, wake_n_i, wake_n_o, wake_n_oe;
  logic internal_reset;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  pmr_pstate_t power_state;
  int n_errors, n_compared, n_irst, k;
  pmr_regs u_dut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .bus_reset_n,
    .wake_event, .wake_n_i, .wake_n_o, .wake_n_oe, .power_state,
    .internal_reset);
  pmr_wake_line u_line (.wake_n_o, .wake_n_oe, .wake_n_i);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (internal_reset === 1'b1) n_irst++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d}, 4'h3);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, e);
  endtask
  task automatic wake_pulse();
    wake_event <= 1'b1;
    cyc(4);
    wake_event <= 1'b0;
    cyc(4);
  endtask
  task automatic bus_rst();
    bus_reset_n <= 1'b0;
    cyc(4);
    bus_reset_n <= 1'b1;
    cyc(4);
  endtask
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    summarize();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {bus_reset_n, wake_event} = 2'h2;
    {n_errors, n_compared, n_irst} = '0;
    cyc(8);
    rstn <= 1'b1;
    cyc(3);
    rdc(8'hA0, 32'h0000FE12);
    rdc(8'hA4, 32'h00000000);
    rdc(8'hA8, 32'h00000000);
    wr(8'hA0, 16'h0000);
    rdc(8'hA0, 32'h00007E02);
    apb(1'b1, 8'hA0, 32'hFFFFFFFF, 4'hF);
    rdc(8'hA0, 32'h0000FE12);
    wr(8'hA4, 16'h7EFC);
    rdc(8'hA4, 32'h00000000);
    for (k = 1; k < 4; k++) begin
      wr(8'hA4, 16'h0100 | 16'(k));
      rdc(8'hA4, 32'h00000100 | 32'(k));
      chk({30'h0, power_state}, 32'(k));
    end
    n_irst = 0;
    wr(8'hA4, 16'h0100);
    // the pulse is still running while this read is set up
    rdc(8'hA8, 32'h00000004);
    cyc(6);
    chk(32'(n_irst), 32'h4);
    rdc(8'hA4, 32'h00000100);
    wr(8'hA4, 16'h0000);
    wake_pulse();
    rdc(8'hA4, 32'h00008000);
    chk({31'h0, wake_n_oe}, 32'h0);
    wr(8'hA4, 16'h0000);
    rdc(8'hA4, 32'h00008000);
    bus_rst();
    rdc(8'hA4, 32'h00000000);
    wr(8'hA4, 16'h0102);
    wake_pulse();
    chk({31'h0, wake_n_i}, 32'h0);
    chk({31'h0, wake_n_o}, 32'h0);
    rdc(8'hA8, 32'h00000003);
    bus_rst();
    rdc(8'hA4, 32'h00008100);
    wr(8'hA4, 16'h8100);
    cyc(2);
    chk({31'h0, wake_n_oe}, 32'h0);
    rdc(8'hA4, 32'h00000100);
    rdc(8'h10, 32'h00000000);
    chk({31'h0, er}, 32'h1);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(3);
    rdc(8'hA4, 32'h00000000);
    summarize();
  end
endmodule // pmr_regs_tb

// [verif/pmr_wake_line.sv]
`timescale 1ns/1ps
module pmr_wake_line (
  // open-drain drive from the block
  input wire logic wake_n_o,
  input wire logic wake_n_oe,
  // resolved line level
  output logic wake_n_i
);
  // line has a pull-up, so it floats high when released
  assign wake_n_i = wake_n_oe ? wake_n_o : 1'b1;
endmodule // pmr_wake_line
